// ===== rtl/rcnc_pkg.sv
package rcnc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int RCNC_ADDR_W = 8;
	localparam logic [RCNC_ADDR_W-1:0] RCNC_OFS_CAUSE = 8'h00;
	localparam logic [RCNC_ADDR_W-1:0] RCNC_OFS_SW_RESET_ARM = 8'h04;
	localparam logic [RCNC_ADDR_W-1:0] RCNC_OFS_NMI = 8'h08;

	// ------------------------------------------------------------
	// reset cause fields
	// ------------------------------------------------------------
	localparam int RCNC_CAUSE_POR = 0;
	localparam int RCNC_CAUSE_BOR = 1;
	localparam int RCNC_CAUSE_IDLE = 2;
	localparam int RCNC_CAUSE_SLEEP = 3;
	localparam int RCNC_CAUSE_WATCHDOG_TIMEOUT_CAUSE = 4;
	localparam int RCNC_CAUSE_SWR = 6;
	localparam logic [31:0] RCNC_CAUSE_MASK = 32'h0000_005F;
	localparam logic [31:0] RCNC_CAUSE_RESET = 32'h0000_0003;

	// ------------------------------------------------------------
	// software reset trigger fields
	// ------------------------------------------------------------
	localparam int RCNC_SW_RESET_ARM_ARM = 0;

	// ------------------------------------------------------------
	// nmi control fields
	// ------------------------------------------------------------
	localparam int RCNC_NMI_RUN_WATCHDOG_NMI_FLAG = 24;
	localparam int RCNC_NMI_SOFT = 23;
	localparam int RCNC_NMI_GEN = 19;
	localparam int RCNC_NMI_CF = 17;
	localparam int RCNC_NMI_SLEEP_WATCHDOG_FLAG = 16;
	localparam int RCNC_NMI_CNT_W = 16;
	localparam logic [31:0] RCNC_NMI_FLAG_MASK = 32'h018B_0000;
	localparam logic [31:0] RCNC_NMI_MASK = 32'h018B_FFFF;
	localparam logic [31:0] RCNC_NMI_RESET = 32'h0000_0000;
	localparam logic [RCNC_NMI_CNT_W-1:0] RCNC_CNT_ZERO = 16'h0000;
	localparam logic [RCNC_NMI_CNT_W-1:0] RCNC_CNT_ONE = 16'h0001;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [RCNC_ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} rcnc_bus_t;

	typedef struct packed {
		logic wake_sleep;
		logic wake_idle;
		logic brownout;
		logic power_on;
		logic wdt_timeout;
		logic in_sleep;
		logic clock_fail;
	} rcnc_evt_t;

	typedef enum logic {RCNC_CNT_IDLE, RCNC_CNT_RUN} rcnc_cnt_state_t;

endpackage

// ===== rtl/rcnc_top.sv
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// - wake from sleep sets cause bit 3
// - leaving idle sets cause bit 2; waking from sleep sets it too
// - brown-out reset sets cause bit 1
// - power-on reset sets cause bit 0
// - cause flags stay set until software writes them clear
// - writing 1 to trigger bit 0 arms software reset; hardware clears it
// - trigger writes without unlock are ignored
// - once armed, any read of trigger register resets the device
// - run-mode watchdog time-out sets bit 24, raises nmi, starts counter
// - software setting bit 24 acts like a real time-out, except that cause bit 4 is not set
// - soft nmi trigger bit 23 raises nmi and reads 1
// - general soft nmi trigger bit 19 raises nmi and reads 1
// - clock failure sets bit 17 and raises nmi
// - software setting bit 17 raises nmi without clock switch
// - sleep watchdog time-out sets bit 16 and wakes; software set gives nmi
// - reload field gives clock cycles from watchdog nmi to reset
// - reload zero resets at once on watchdog nmi
// - clearing run watchdog flag before zero prevents reset
// - only watchdog nmi starts the delay counter
// - nmi control writes need unlock
// - executed software reset sets cause bit 6
// - watchdog time-out sets cause bit 4
module rcnc_top
	import rcnc_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire rcnc_bus_t bus,
	input wire logic unlock,
	input wire rcnc_evt_t evt,
	output logic [31:0] rd_data,
	output logic nmi_req,
	output logic dev_reset,
	output logic wake_req,
	output logic clk_switch_req
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [RCNC_ADDR_W-1:0] a,
			input logic [RCNC_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	logic cause_wr;
	logic trig_wr;
	logic trig_rd;
	logic nmi_wr;
	assign cause_wr = bus.wr && hit(bus.addr, RCNC_OFS_CAUSE);
	assign trig_wr = bus.wr && unlock && hit(bus.addr, RCNC_OFS_SW_RESET_ARM);
	assign trig_rd = bus.rd && hit(bus.addr, RCNC_OFS_SW_RESET_ARM);
	assign nmi_wr = bus.wr && unlock && hit(bus.addr, RCNC_OFS_NMI);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [31:0] cause_reg;
	logic [31:0] cause_next;
	logic [31:0] nmi_ctl_reg;
	logic [31:0] nmi_ctl_next;
	logic sw_arm_reg;
	logic [RCNC_NMI_CNT_W-1:0] cnt_reg;
	rcnc_cnt_state_t cnt_state_reg;
	logic [31:0] rd_data_reg;
	logic nmi_req_reg;
	logic dev_reset_reg;
	logic wake_req_reg;
	logic clk_switch_req_reg;

	logic run_wdt;
	logic sleep_wdt;
	logic sw_fire;
	logic wdt_start;
	logic wdt_fire;
	logic [RCNC_NMI_CNT_W-1:0] reload;

	assign run_wdt = evt.wdt_timeout && !evt.in_sleep;
	assign sleep_wdt = evt.wdt_timeout && evt.in_sleep;
	assign sw_fire = sw_arm_reg && trig_rd;
	assign reload = nmi_ctl_reg[RCNC_NMI_CNT_W-1:0];
	// rising flag covers both a real time-out and a software set
	assign wdt_start = nmi_ctl_next[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG] && !nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG];

	// ------------------------------------------------------------
	// reset cause flags
	// ------------------------------------------------------------
	always_comb begin
		cause_next = cause_reg;
		if (cause_wr) begin
			cause_next = bus.wdata & RCNC_CAUSE_MASK;
		end
		// hardware set wins over a clearing write in the same cycle
		if (evt.wake_sleep) begin
			cause_next[RCNC_CAUSE_SLEEP] = 1'b1;
			cause_next[RCNC_CAUSE_IDLE] = 1'b1;
		end
		if (evt.wake_idle) begin
			cause_next[RCNC_CAUSE_IDLE] = 1'b1;
		end
		if (evt.brownout) begin
			cause_next[RCNC_CAUSE_BOR] = 1'b1;
		end
		if (evt.power_on) begin
			cause_next[RCNC_CAUSE_POR] = 1'b1;
		end
		if (evt.wdt_timeout) begin
			cause_next[RCNC_CAUSE_WATCHDOG_TIMEOUT_CAUSE] = 1'b1;
		end
		if (sw_fire) begin
			cause_next[RCNC_CAUSE_SWR] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cause_reg <= RCNC_CAUSE_RESET;
		end else begin
			cause_reg <= cause_next;
		end
	end

	// ------------------------------------------------------------
	// software reset trigger
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_arm_reg <= 1'b0;
		end else if (sw_fire) begin
			sw_arm_reg <= 1'b0;
		end else if (trig_wr && bus.wdata[RCNC_SW_RESET_ARM_ARM]) begin
			sw_arm_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// nmi control
	// ------------------------------------------------------------
	always_comb begin
		nmi_ctl_next = nmi_ctl_reg;
		if (nmi_wr) begin
			nmi_ctl_next = bus.wdata & RCNC_NMI_MASK;
		end
		if (run_wdt) begin
			nmi_ctl_next[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG] = 1'b1;
		end
		if (sleep_wdt) begin
			nmi_ctl_next[RCNC_NMI_SLEEP_WATCHDOG_FLAG] = 1'b1;
		end
		if (evt.clock_fail) begin
			nmi_ctl_next[RCNC_NMI_CF] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_ctl_reg <= RCNC_NMI_RESET;
		end else begin
			nmi_ctl_reg <= nmi_ctl_next;
		end
	end

	// any pending flag, set by hardware or software, holds the nmi
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nmi_req_reg <= 1'b0;
		end else begin
			nmi_req_reg <= |(nmi_ctl_reg & RCNC_NMI_FLAG_MASK);
		end
	end

	// ------------------------------------------------------------
	// delayed reset counter
	// ------------------------------------------------------------
	// a rising flag implies the flag was clear, so the count term cannot fire then even if the counter is still in RUN
	assign wdt_fire = (wdt_start && (reload == RCNC_CNT_ZERO))
		|| ((cnt_state_reg == RCNC_CNT_RUN) && nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG]
		&& (cnt_reg == RCNC_CNT_ONE));

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_state_reg <= RCNC_CNT_IDLE;
			cnt_reg <= RCNC_CNT_ZERO;
		end else begin
			case (cnt_state_reg)
				RCNC_CNT_IDLE: begin
					// only the run watchdog flag can start it
					if (wdt_start && (reload != RCNC_CNT_ZERO)) begin
						cnt_reg <= reload;
						cnt_state_reg <= RCNC_CNT_RUN;
					end
				end
				RCNC_CNT_RUN: begin
					if (!nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG] && wdt_start && (reload != RCNC_CNT_ZERO)) begin
						// fresh time-out right after a clear must not be lost
						cnt_reg <= reload;
					end else if (!nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG]) begin
						cnt_state_reg <= RCNC_CNT_IDLE;
						cnt_reg <= RCNC_CNT_ZERO;
					end else if (cnt_reg == RCNC_CNT_ONE) begin
						cnt_state_reg <= RCNC_CNT_IDLE;
						cnt_reg <= RCNC_CNT_ZERO;
					end else begin
						cnt_reg <= cnt_reg - RCNC_CNT_ONE;
					end
				end
				default: begin
					cnt_state_reg <= RCNC_CNT_IDLE;
					cnt_reg <= RCNC_CNT_ZERO;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dev_reset_reg <= 1'b0;
		end else begin
			dev_reset_reg <= sw_fire || wdt_fire;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wake_req_reg <= 1'b0;
			clk_switch_req_reg <= 1'b0;
		end else begin
			wake_req_reg <= sleep_wdt;
			// software setting the clock-fail flag never switches clocks
			clk_switch_req_reg <= evt.clock_fail;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data_reg <= 32'h0000_0000;
		end else if (bus.rd && hit(bus.addr, RCNC_OFS_CAUSE)) begin
			rd_data_reg <= cause_reg;
		end else if (bus.rd && hit(bus.addr, RCNC_OFS_NMI)) begin
			rd_data_reg <= nmi_ctl_reg;
		end else begin
			// trigger register and unmapped space read zero
			rd_data_reg <= 32'h0000_0000;
		end
	end

	assign rd_data = rd_data_reg;
	assign nmi_req = nmi_req_reg;
	assign dev_reset = dev_reset_reg;
	assign wake_req = wake_req_reg;
	assign clk_switch_req = clk_switch_req_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_sleep_wake;
		evt.wake_sleep |=> cause_reg[RCNC_CAUSE_SLEEP] && cause_reg[RCNC_CAUSE_IDLE];
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake flags not set");

	property p_idle_wake;
		evt.wake_idle |=> cause_reg[RCNC_CAUSE_IDLE];
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake flag not set");

	property p_bor;
		evt.brownout |=> cause_reg[RCNC_CAUSE_BOR];
	endproperty
	a_bor: assert property (p_bor) else $error("brown-out flag not set");

	property p_por;
		evt.power_on |=> cause_reg[RCNC_CAUSE_POR];
	endproperty
	a_por: assert property (p_por) else $error("power-on flag not set");

	property p_sticky;
		(cause_reg[RCNC_CAUSE_BOR] && !cause_wr) |=> cause_reg[RCNC_CAUSE_BOR];
	endproperty
	a_sticky: assert property (p_sticky) else $error("cause flag lost without write");

	property p_locked_trig;
		(bus.wr && !unlock && hit(bus.addr, RCNC_OFS_SW_RESET_ARM) && !sw_arm_reg) |=> !sw_arm_reg;
	endproperty
	a_locked_trig: assert property (p_locked_trig) else $error("locked trigger write armed");

	sequence s_armed_read;
		sw_arm_reg ##0 trig_rd;
	endsequence
	property p_sw_reset;
		s_armed_read |=> dev_reset_reg && !sw_arm_reg && cause_reg[RCNC_CAUSE_SWR];
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("armed read did not reset");

	property p_trig_reads_zero;
		trig_rd |=> rd_data_reg == 32'h0000_0000;
	endproperty
	a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read not zero");

	property p_run_wdt;
		run_wdt |=> nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG] ##1 nmi_req_reg;
	endproperty
	a_run_wdt: assert property (p_run_wdt) else $error("run watchdog nmi missing");

	property p_soft_nmi;
		(nmi_wr && bus.wdata[RCNC_NMI_SOFT]) |=> nmi_ctl_reg[RCNC_NMI_SOFT] ##1 nmi_req_reg;
	endproperty
	a_soft_nmi: assert property (p_soft_nmi) else $error("soft nmi missing");

	property p_clock_fail;
		evt.clock_fail |=> nmi_ctl_reg[RCNC_NMI_CF] && clk_switch_req_reg ##1 nmi_req_reg;
	endproperty
	a_clock_fail: assert property (p_clock_fail) else $error("clock fail nmi missing");

	property p_no_soft_switch;
		clk_switch_req_reg |-> $past(evt.clock_fail);
	endproperty
	a_no_soft_switch: assert property (p_no_soft_switch) else $error("clock switch without fail");

	property p_zero_reload;
		(wdt_start && reload == RCNC_CNT_ZERO && cnt_state_reg == RCNC_CNT_IDLE) |=> dev_reset_reg;
	endproperty
	a_zero_reload: assert property (p_zero_reload) else $error("zero reload did not reset");

	sequence s_wdt_three;
		($rose(nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG]) && cnt_reg == 16'h0003) ##0 nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG][*3];
	endsequence
	property p_delay_three;
		s_wdt_three |-> !dev_reset_reg ##1 dev_reset_reg;
	endproperty
	a_delay_three: assert property (p_delay_three) else $error("delayed reset off count");

	property p_cleared_quiet;
		(cnt_state_reg == RCNC_CNT_RUN && !nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG] && !sw_fire && !wdt_start)
			|=> !dev_reset_reg;
	endproperty
	a_cleared_quiet: assert property (p_cleared_quiet) else $error("reset after flag cleared");

	property p_only_wdt_counts;
		$rose(cnt_state_reg == RCNC_CNT_RUN) |-> $rose(nmi_ctl_reg[RCNC_NMI_RUN_WATCHDOG_NMI_FLAG]);
	endproperty
	a_only_wdt_counts: assert property (p_only_wdt_counts) else $error("counter started by other nmi");

	property p_locked_nmi;
		(bus.wr && !unlock && hit(bus.addr, RCNC_OFS_NMI) && !evt.wdt_timeout && !evt.clock_fail)
			|=> $stable(nmi_ctl_reg);
	endproperty
	a_locked_nmi: assert property (p_locked_nmi) else $error("locked nmi write took effect");

	property p_sleep_wdt;
		sleep_wdt |=> nmi_ctl_reg[RCNC_NMI_SLEEP_WATCHDOG_FLAG] && wake_req_reg && cause_reg[RCNC_CAUSE_WATCHDOG_TIMEOUT_CAUSE];
	endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep watchdog not flagged");

endmodule // rcnc_top

// ===== sim/reset_cause_nmi_control_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module reset_cause_nmi_control_test;
	import rcnc_pkg::*;

	// ------------------------------------------------------------
	// signals and model state
	// ------------------------------------------------------------
	logic clk;
	logic reset_n;
	rcnc_bus_t bus;
	logic unlock;
	rcnc_evt_t evt;
	logic [31:0] rd_data;
	logic nmi_req;
	logic dev_reset;
	logic wake_req;
	logic clk_switch_req;
	int n_fail = 0;
	int checks = 0;
	int n_rst = 0;
	int n_sw = 0;
	int n_wake = 0;
	logic [31:0] cause_m;
	logic [31:0] nmi_m;
	logic [6:0] ev_pat[4] = '{7'h40, 7'h20, 7'h10, 7'h08};
	logic [31:0] ev_exp[4] = '{32'h0000_000C, 32'h0000_0004, 32'h0000_0002, 32'h0000_0001};
	int trig_bit[4] = '{23, 19, 17, 16};

	rcnc_top i_dut (
		.clk(clk),
		.reset_n(reset_n),
		.bus(bus),
		.unlock(unlock),
		.evt(evt),
		.rd_data(rd_data),
		.nmi_req(nmi_req),
		.dev_reset(dev_reset),
		.wake_req(wake_req),
		.clk_switch_req(clk_switch_req)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// pulse outputs are tallied here so no pulse slips between two reads
	always @(posedge clk) begin
		if (dev_reset === 1'b1) n_rst++;
		if (clk_switch_req === 1'b1) n_sw++;
		if (wake_req === 1'b1) n_wake++;
	end

	// ------------------------------------------------------------
	// bus and event tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic u);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		unlock <= u;
		@(posedge clk);
		bus.wr <= 1'b0;
		if (a === RCNC_OFS_CAUSE) cause_m = d & RCNC_CAUSE_MASK;
		else if (a === RCNC_OFS_NMI && u) nmi_m = d & RCNC_NMI_MASK;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		q = rd_data;
	endtask

	task automatic pulse(input logic [6:0] e);
		@(posedge clk);
		evt <= rcnc_evt_t'(e);
		@(posedge clk);
		evt <= '0;
	endtask

	task automatic chk_regs();
		logic [31:0] q;
		rd(RCNC_OFS_CAUSE, q);
		`CHK(q, cause_m)
		rd(RCNC_OFS_NMI, q);
		`CHK(q, nmi_m)
		`CHK(nmi_req, |(nmi_m & RCNC_NMI_FLAG_MASK))
	endtask

	// counts edges from the sampling edge until the reset pulse shows
	task automatic wait_rst(output int n);
		#1;
		n = 0;
		while (dev_reset !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask

	task automatic complete_run();
		if (n_fail == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_fail++;
		complete_run();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] q;
		logic [15:0] r;
		logic [7:0] a;
		int n;
		int base;
		int base_sw;
		bus = '0;
		evt = '0;
		unlock = 1'b0;
		reset_n = 1'b0;
		void'($urandom(18126));
		repeat (16) @(posedge clk);
		#1 `CHK({nmi_req, dev_reset, wake_req, clk_switch_req}, 4'h0)
		@(posedge clk) reset_n <= 1'b1;
		cause_m = RCNC_CAUSE_RESET;
		nmi_m = RCNC_NMI_RESET;
		chk_regs();
		for (int k = 0; k < 4; k++) begin
			wr(RCNC_OFS_CAUSE, 32'h0000_0000, 1'b0);
			pulse(ev_pat[k]);
			cause_m |= ev_exp[k];
			chk_regs();
		end
		wr(RCNC_OFS_CAUSE, $urandom, 1'b0);
		chk_regs();
		wr(RCNC_OFS_CAUSE, 32'h0000_0000, 1'b0);
		a = 8'h10 + 8'($urandom_range(0, 200));
		wr(a, $urandom, 1'b1);
		rd(a, q);
		`CHK(q, 32'h0000_0000)
		// software reset: locked write, zero write, then a real arm
		base = n_rst;
		wr(RCNC_OFS_SW_RESET_ARM, 32'h0000_0001, 1'b0);
		rd(RCNC_OFS_SW_RESET_ARM, q);
		repeat (3) @(posedge clk);
		`CHK(32'(n_rst), 32'(base))
		wr(RCNC_OFS_SW_RESET_ARM, 32'h0000_0000, 1'b1);
		rd(RCNC_OFS_SW_RESET_ARM, q);
		repeat (3) @(posedge clk);
		`CHK(32'(n_rst), 32'(base))
		wr(RCNC_OFS_SW_RESET_ARM, 32'h0000_0001, 1'b1);
		rd(RCNC_OFS_SW_RESET_ARM, q);
		`CHK(q, 32'h0000_0000)
		repeat (3) @(posedge clk);
		`CHK(32'(n_rst), 32'(base + 1))
		cause_m |= 32'h0000_0040;
		chk_regs();
		rd(RCNC_OFS_SW_RESET_ARM, q);
		repeat (3) @(posedge clk);
		`CHK(32'(n_rst), 32'(base + 1))
		// watchdog delayed reset, boundary reloads and a random one
		for (int rep = 0; rep < 4; rep++) begin
			// one pass at three so the counted-delay check sees a real start
			r = (rep < 2) ? 16'(rep) : ((rep == 2) ? 16'h0003 : 16'($urandom_range(2, 40)));
			wr(RCNC_OFS_CAUSE, 32'h0000_0000, 1'b0);
			wr(RCNC_OFS_NMI, {16'h0000, r}, 1'b1);
			if (rep % 2 == 0) begin
				pulse(7'h04);
				nmi_m |= 32'h0100_0000;
				cause_m |= 32'h0000_0010;
			end else begin
				wr(RCNC_OFS_NMI, {16'h0100, r}, 1'b1);
			end
			wait_rst(n);
			`CHK(32'(n), 32'(r))
			rd(RCNC_OFS_NMI, q);
			`CHK(q, nmi_m)
			if (rep % 2 == 0) chk_regs();
			wr(RCNC_OFS_NMI, 32'h0000_0000, 1'b1);
		end
		// clearing the run flag mid-count must cancel the reset
		wr(RCNC_OFS_NMI, 32'h0000_0014, 1'b1);
		base = n_rst;
		pulse(7'h04);
		cause_m |= 32'h0000_0010;
		wr(RCNC_OFS_NMI, 32'h0000_0014, 1'b1);
		repeat (40) @(posedge clk);
		`CHK(32'(n_rst), 32'(base))
		// sleep time-out wakes and raises nmi; clock failure switches clocks but starts no countdown
		wr(RCNC_OFS_NMI, 32'h0000_0002, 1'b1);
		base = n_wake;
		pulse(7'h06);
		nmi_m |= 32'h0001_0000;
		repeat (3) @(posedge clk);
		`CHK(32'(n_wake), 32'(base + 1))
		chk_regs();
		base = n_rst;
		pulse(7'h01);
		#1 `CHK(clk_switch_req, 1'b1)
		nmi_m |= 32'h0002_0000;
		chk_regs();
		repeat (10) @(posedge clk);
		`CHK(32'(n_rst), 32'(base))
		wr(RCNC_OFS_NMI, 32'h0000_0000, 1'b1);
		// software sources: locked first, then unlocked with a zero reload
		for (int k = 0; k < 4; k++) begin
			base = n_rst;
			base_sw = n_sw;
			wr(RCNC_OFS_NMI, 32'h1 << trig_bit[k], 1'b0);
			chk_regs();
			wr(RCNC_OFS_NMI, 32'h1 << trig_bit[k], 1'b1);
			chk_regs();
			`CHK(32'(n_rst), 32'(base))
			`CHK(32'(n_sw), 32'(base_sw))
			wr(RCNC_OFS_NMI, 32'h0000_0000, 1'b1);
		end
		chk_regs();
		complete_run();
	end

endmodule // reset_cause_nmi_control_test
